// ---- rtl/ext_io_pkg.sv ----
package ext_io_pkg;
	// ***********************************************
	// register map, byte addresses on the bus
	// ***********************************************
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] OFF_INPUT_STATE = 5'h00;
	localparam logic [ADDR_W-1:0] OFF_OUTPUT_STATE = 5'h04;
	localparam logic [ADDR_W-1:0] OFF_OVERRIDE_SELECT = 5'h08;
	localparam logic [ADDR_W-1:0] OFF_OVERRIDE_VALUE = 5'h0c;
	localparam logic [ADDR_W-1:0] OFF_RELAY_A_SOURCE = 5'h10;

	// ***********************************************
	// field positions and reset values
	// ***********************************************
	localparam int BIT_RELAY_A = 0;
	localparam int BIT_RELAY_B = 1;
	localparam int BIT_DIGITAL_OUT = 5;
	localparam logic [15:0] OVERRIDE_MASK = 16'h0023;
	localparam logic [15:0] RESET_OVERRIDE = 16'h0000;
	localparam logic [15:0] RESET_RELAY_A_SOURCE = 16'h0000;
	localparam int INPUT_COUNT = 6;

	// ***********************************************
	// relay a source codes
	// ***********************************************
	localparam logic [15:0] SRC_OFF = 16'h0000;
	localparam logic [15:0] SRC_ON = 16'h0001;
	localparam logic [15:0] SRC_READY_RUN = 16'h0002;
	localparam logic [15:0] SRC_ENABLED = 16'h0004;
	localparam logic [15:0] SRC_STARTED = 16'h0005;
	localparam logic [15:0] SRC_MAGNETIZED = 16'h0006;
	localparam logic [15:0] SRC_RUNNING = 16'h0007;
	localparam logic [15:0] SRC_READY_REF = 16'h0008;

	// bus answer states, one-hot
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_ACK = 2'b10
	} bus_state_t;
endpackage

// ---- rtl/input_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module input_sync #(
	parameter int WIDTH = 6
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;
	logic [WIDTH-1:0] next_dout;

	// a bit changes only once stages two and three agree
	always_comb begin
		next_dout = dout;
		for (int i = 0; i < WIDTH; i++) begin
			if (s2[i] == s3[i]) begin
				next_dout[i] = s3[i];
			end
		end
	end

	// s1 feeds only s2, never any logic
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			dout <= '0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			dout <= next_dout;
		end
	end
endmodule // input_sync
`default_nettype wire

// ---- rtl/extension_io_status_force.sv ----
`timescale 1ns/1ns
`default_nettype none
// Contract
// - input status word carries the six inputs, first input in bit 0, rest in order.
// - output status word carries relay a, relay b in bits 0-1 and digital out in bit 5.
// - both status words are read-only and writes to them change nothing.
// - a set override-select bit drives its output to the matching override-value bit.
// - override-select bit 0 is relay a, bit 1 relay b, bit 5 digital out; others reserved.
// - reset clears override-select and override-value to zero.
// - an override-value bit has no effect unless its select bit is set.
// - override-value holds relay values in bits 0 and 1 and digital out value in bit 5.
// - relay a source code 0 keeps it off and code 1 keeps it on.
// - codes 2,4,5,6,7,8 route ready-run, enabled, started, magnetized, running, ready-ref.
module extension_io_status_force
	import ext_io_pkg::*;
#(
	parameter int INPUTS = ext_io_pkg::INPUT_COUNT
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [ext_io_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic [INPUTS-1:0] ext_input_pins,
	input wire logic drive_ready_run,
	input wire logic drive_enabled,
	input wire logic drive_started,
	input wire logic drive_magnetized,
	input wire logic drive_running,
	input wire logic drive_ready_ref,
	input wire logic relay_b_source,
	input wire logic digital_out_source,
	output logic ext_relay_a,
	output logic ext_relay_b,
	output logic ext_digital_out
);
	import ext_io_pkg::*;

	// ***********************************************
	// declarations
	// ***********************************************
	bus_state_t bus_state;
	bus_state_t next_state;
	logic next_waitrequest;
	logic [31:0] next_readdata;
	logic [ADDR_W-1:0] held_addr;
	logic [ADDR_W-1:0] next_addr;
	logic held_write;
	logic next_wr;
	logic [15:0] override_select;
	logic [15:0] override_value;
	logic [15:0] relay_a_source_select;
	logic [15:0] next_select;
	logic [15:0] next_value;
	logic [15:0] next_source;
	logic [INPUTS-1:0] ext_input_state;
	logic [15:0] input_word;
	logic [15:0] output_word;
	logic normal_a;
	logic next_relay_a;
	logic next_relay_b;
	logic next_digital_out;
	logic commit;

	// byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(
		input logic [15:0] old,
		input logic [31:0] wd,
		input logic [3:0] be
	);
		logic [15:0] r;
		r = old;
		if (be[0]) begin
			r[7:0] = wd[7:0];
		end
		if (be[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction

	// ***********************************************
	// input pins
	// ***********************************************
	// pins are asynchronous to clk_sys
	input_sync #(
		.WIDTH(INPUTS)
	) u_in_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.din(ext_input_pins),
		.dout(ext_input_state)
	);

	// ***********************************************
	// status words
	// ***********************************************
	// status reflects what is really driven, not the request
	always_comb begin
		input_word = '0;
		input_word[INPUTS-1:0] = ext_input_state;
		output_word = '0;
		output_word[BIT_RELAY_A] = ext_relay_a;
		output_word[BIT_RELAY_B] = ext_relay_b;
		output_word[BIT_DIGITAL_OUT] = ext_digital_out;
	end

	// ***********************************************
	// bus slave
	// ***********************************************
	// one wait cycle: answer follows the first sampled request
	always_comb begin
		next_state = bus_state;
		next_waitrequest = waitrequest;
		next_readdata = readdata;
		next_addr = held_addr;
		next_wr = held_write;
		case (bus_state)
			ST_IDLE: begin
				if (read || write) begin
					next_state = ST_ACK;
					next_waitrequest = 1'b0;
					next_addr = address;
					next_wr = write;
					next_readdata = '0;
					if (read) begin
						case (address)
							OFF_INPUT_STATE: next_readdata = {16'h0000, input_word};
							OFF_OUTPUT_STATE: next_readdata = {16'h0000, output_word};
							OFF_OVERRIDE_SELECT: next_readdata = {16'h0000, override_select};
							OFF_OVERRIDE_VALUE: next_readdata = {16'h0000, override_value};
							OFF_RELAY_A_SOURCE: begin
								next_readdata = {16'h0000, relay_a_source_select};
							end
							default: next_readdata = '0; // unmapped reads zero
						endcase
					end
				end
			end
			ST_ACK: begin
				next_state = ST_IDLE;
				next_waitrequest = 1'b1;
			end
			default: begin
				next_state = ST_IDLE;
				next_waitrequest = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bus_state <= ST_IDLE;
			waitrequest <= 1'b1;
			readdata <= '0;
			held_addr <= '0;
			held_write <= 1'b0;
		end else begin
			bus_state <= next_state;
			waitrequest <= next_waitrequest;
			readdata <= next_readdata;
			held_addr <= next_addr;
			held_write <= next_wr;
		end
	end

	// ***********************************************
	// software registers
	// ***********************************************
	// a write lands on the edge where waitrequest is seen low
	assign commit = (bus_state == ST_ACK) && held_write;

	// status offsets and unmapped offsets fall through untouched
	always_comb begin
		next_select = override_select;
		next_value = override_value;
		next_source = relay_a_source_select;
		if (commit) begin
			case (held_addr)
				OFF_OVERRIDE_SELECT: begin
					next_select = merge16(override_select, writedata, byteenable)
						& OVERRIDE_MASK;
				end
				OFF_OVERRIDE_VALUE: begin
					next_value = merge16(override_value, writedata, byteenable)
						& OVERRIDE_MASK;
				end
				OFF_RELAY_A_SOURCE: begin
					next_source = merge16(relay_a_source_select, writedata,
						byteenable);
				end
				default: begin
					next_select = override_select;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			override_select <= RESET_OVERRIDE;
			override_value <= RESET_OVERRIDE;
			relay_a_source_select <= RESET_RELAY_A_SOURCE;
		end else begin
			override_select <= next_select;
			override_value <= next_value;
			relay_a_source_select <= next_source;
		end
	end

	// ***********************************************
	// output drive
	// ***********************************************
	// unlisted codes leave the relay de-energized, the safe side
	always_comb begin
		case (relay_a_source_select)
			SRC_OFF: normal_a = 1'b0;
			SRC_ON: normal_a = 1'b1;
			SRC_READY_RUN: normal_a = drive_ready_run;
			SRC_ENABLED: normal_a = drive_enabled;
			SRC_STARTED: normal_a = drive_started;
			SRC_MAGNETIZED: normal_a = drive_magnetized;
			SRC_RUNNING: normal_a = drive_running;
			SRC_READY_REF: normal_a = drive_ready_ref;
			default: normal_a = 1'b0;
		endcase
	end

	// override value counts only under its select bit
	always_comb begin
		next_relay_a = override_select[BIT_RELAY_A] ?
			override_value[BIT_RELAY_A] : normal_a;
		next_relay_b = override_select[BIT_RELAY_B] ?
			override_value[BIT_RELAY_B] : relay_b_source;
		next_digital_out = override_select[BIT_DIGITAL_OUT] ?
			override_value[BIT_DIGITAL_OUT] : digital_out_source;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ext_relay_a <= 1'b0;
			ext_relay_b <= 1'b0;
			ext_digital_out <= 1'b0;
		end else begin
			ext_relay_a <= next_relay_a;
			ext_relay_b <= next_relay_b;
			ext_digital_out <= next_digital_out;
		end
	end

	// ***********************************************
	// checks
	// ***********************************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	sequence seq_take(logic [ADDR_W-1:0] a);
		bus_state == ST_IDLE && read && !write && address == a;
	endsequence

	sequence seq_commit(logic [ADDR_W-1:0] a);
		bus_state == ST_ACK && held_write && held_addr == a;
	endsequence

	chk_input_order: assert property (
		seq_take(OFF_INPUT_STATE) |=> readdata[31:INPUTS] == '0 &&
			readdata[INPUTS-1:0] == $past(ext_input_state)
	) else $error("input status word wrong");

	chk_output_report: assert property (
		seq_take(OFF_OUTPUT_STATE) |=> !waitrequest &&
			readdata[BIT_DIGITAL_OUT] == $past(ext_digital_out) &&
			readdata[1:0] == {$past(ext_relay_b), $past(ext_relay_a)} &&
			readdata[4:2] == 3'h0
	) else $error("output status word wrong");

	chk_ro_ignore: assert property (
		seq_commit(OFF_OUTPUT_STATE) or seq_commit(OFF_INPUT_STATE) |=>
			$stable(override_select) && $stable(override_value) &&
			$stable(relay_a_source_select)
	) else $error("status write changed a register");

	chk_force_apply: assert property (
		override_select[BIT_DIGITAL_OUT] |=>
			ext_digital_out == $past(override_value[BIT_DIGITAL_OUT])
	) else $error("forced output not applied");

	chk_reserved_zero: assert property (
		(override_select & ~OVERRIDE_MASK) == 16'h0000
	) else $error("reserved select bits set");

	chk_reset_clear: assert property (
		@(posedge clk_sys) disable iff (1'b0)
		rst |=> override_select == 16'h0000 && override_value == 16'h0000
	) else $error("override words not cleared");

	chk_value_inert: assert property (
		!override_select[BIT_RELAY_B] |=>
			ext_relay_b == $past(relay_b_source)
	) else $error("unselected value reached relay b");

	chk_value_write: assert property (
		seq_commit(OFF_OVERRIDE_VALUE) and byteenable[0] |=>
			override_value[BIT_DIGITAL_OUT] == $past(writedata[BIT_DIGITAL_OUT])
			&& override_value[1:0] == $past(writedata[1:0])
	) else $error("override value not stored");

	chk_fixed_codes: assert property (
		!override_select[BIT_RELAY_A] && relay_a_source_select == SRC_ON
		|=> ext_relay_a
	) else $error("energized code not honoured");

	chk_status_route: assert property (
		!override_select[BIT_RELAY_A] &&
		relay_a_source_select == SRC_RUNNING |=>
			ext_relay_a == $past(drive_running)
	) else $error("running status not routed");

	chk_follow_normal: assert property (
		!override_select[BIT_DIGITAL_OUT] |=>
			ext_digital_out == $past(digital_out_source)
	) else $error("digital out not following source");
endmodule // extension_io_status_force
`default_nettype wire

// ---- test/ext_module_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ***********************************************
// far side: extension module terminals
// ***********************************************
module ext_module_model (
	input wire logic [5:0] pattern,
	input wire logic ext_relay_a,
	input wire logic ext_relay_b,
	input wire logic ext_digital_out,
	output logic [5:0] pins,
	output logic [2:0] loads
);
	// field inputs move right after an edge; no bounce is modelled,
	// so the synchroniser only ever sees clean steps
	assign pins = pattern; // first input on pins[0]
	// energized loads as seen at the terminals
	assign loads = {ext_digital_out, ext_relay_b, ext_relay_a};
endmodule // ext_module_model
`default_nettype wire

// ---- test/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import ext_io_pkg::*;
	// ***********************************************
	// clock, reset and hookup
	// ***********************************************
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [ADDR_W-1:0] address = '0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = '0;
	logic [3:0] byteenable = '0;
	logic [31:0] readdata;
	logic waitrequest;
	logic [5:0] pattern = '0;
	logic [5:0] pins;
	logic [5:0] drv = '0;
	logic src_b = 1'b0;
	logic src_d = 1'b0;
	logic relay_a;
	logic relay_b;
	logic dout;
	logic [2:0] loads;
	logic [31:0] rdv;
	int error_cnt = 0;
	int num_checks = 0;
	// rows: source code, drive status vector, expected relay a
	localparam logic [23:0] ROWS [15] = '{24'h00_3f_00, 24'h01_00_01,
		24'h02_01_01, 24'h02_3e_00, 24'h04_02_01, 24'h04_3d_00,
		24'h05_04_01, 24'h05_3b_00, 24'h06_08_01, 24'h06_37_00,
		24'h07_10_01, 24'h07_2f_00, 24'h08_20_01, 24'h08_1f_00,
		24'h03_3f_00};

	always #25 clk_sys = ~clk_sys;

	extension_io_status_force extension_io_status_force_inst (
		.clk_sys(clk_sys), .rst(rst), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest),
		.ext_input_pins(pins), .drive_ready_run(drv[0]),
		.drive_enabled(drv[1]), .drive_started(drv[2]),
		.drive_magnetized(drv[3]), .drive_running(drv[4]),
		.drive_ready_ref(drv[5]), .relay_b_source(src_b),
		.digital_out_source(src_d), .ext_relay_a(relay_a),
		.ext_relay_b(relay_b), .ext_digital_out(dout)
	);
	ext_module_model ext_module_model_inst (
		.pattern(pattern), .ext_relay_a(relay_a), .ext_relay_b(relay_b),
		.ext_digital_out(dout), .pins(pins), .loads(loads)
	);

	// ***********************************************
	// bus master and compare tasks
	// ***********************************************
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// request held until waitrequest is seen low, then one idle edge
	// so the next call never rewrites a strobe in the same step
	task automatic xfer(input logic [ADDR_W-1:0] a, input logic wr,
		input logic [15:0] wd, input logic [3:0] be);
		int n;
		address <= a;
		write <= wr;
		read <= ~wr;
		writedata <= {16'h0000, wd};
		byteenable <= be;
		for (n = 0; n < 16; n++) begin
			@(posedge clk_sys);
			if (waitrequest === 1'b0) break;
		end
		if (n == 16) begin
			error_cnt++;
			summarize();
		end
		rdv = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
		xfer(a, 1'b1, d, 4'hf);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
		xfer(a, 1'b0, 16'h0000, 4'hf);
		chk(rdv, e);
	endtask
	// outputs are registered: two edges cover the update
	task automatic outs(input logic [2:0] e);
		repeat (2) @(posedge clk_sys);
		chk({29'h0, loads}, {29'h0, e});
	endtask

	// ***********************************************
	// main sequence
	// ***********************************************
	initial begin
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		for (int i = 0; i < 15; i++) begin
			drv <= ROWS[i][13:8];
			wr(OFF_RELAY_A_SOURCE, {8'h00, ROWS[i][23:16]});
			outs({2'b00, ROWS[i][0]});
			rd(OFF_OUTPUT_STATE, {31'h0, ROWS[i][0]});
		end
		$display("test source table done");
		pattern <= 6'h09;
		repeat (6) @(posedge clk_sys);
		rd(OFF_INPUT_STATE, 32'h0000_0009);
		pattern <= 6'h36;
		repeat (6) @(posedge clk_sys);
		rd(OFF_INPUT_STATE, 32'h0000_0036);
		wr(OFF_INPUT_STATE, 16'hffff);
		wr(OFF_OUTPUT_STATE, 16'hffff);
		wr(5'h14, 16'hffff);
		rd(OFF_INPUT_STATE, 32'h0000_0036);
		rd(OFF_OUTPUT_STATE, 32'h0000_0000);
		rd(5'h14, 32'h0000_0000);
		rd(OFF_OVERRIDE_VALUE, 32'h0000_0000);
		rd(OFF_RELAY_A_SOURCE, 32'h0000_0003);
		$display("test status words done");
		src_b <= 1'b1;
		wr(OFF_RELAY_A_SOURCE, SRC_ON);
		outs(3'b011);
		src_d <= 1'b1;
		outs(3'b111);
		rd(OFF_OUTPUT_STATE, 32'h0000_0023);
		// upper lane only: no override bit lives there
		xfer(OFF_OVERRIDE_SELECT, 1'b1, 16'h0023, 4'h2);
		rd(OFF_OVERRIDE_SELECT, 32'h0000_0000);
		wr(OFF_OVERRIDE_SELECT, 16'hffff);
		rd(OFF_OVERRIDE_SELECT, 32'h0000_0023);
		outs(3'b000);
		rd(OFF_OUTPUT_STATE, 32'h0000_0000);
		src_b <= 1'b0;
		src_d <= 1'b0;
		wr(OFF_RELAY_A_SOURCE, SRC_OFF);
		wr(OFF_OVERRIDE_VALUE, 16'hffff);
		rd(OFF_OVERRIDE_VALUE, 32'h0000_0023);
		outs(3'b111);
		wr(OFF_OVERRIDE_SELECT, 16'h0002);
		outs(3'b010);
		wr(OFF_OVERRIDE_SELECT, 16'h0000);
		outs(3'b000);
		$display("test override done");
		src_b <= 1'b1;
		src_d <= 1'b1;
		wr(OFF_OVERRIDE_SELECT, 16'h0023);
		wr(OFF_OVERRIDE_VALUE, 16'h0000);
		outs(3'b000);
		// leave both words non-zero so the reset really has work to do
		wr(OFF_OVERRIDE_VALUE, 16'h0021);
		outs(3'b101);
		rst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		outs(3'b110);
		rd(OFF_OVERRIDE_SELECT, 32'h0000_0000);
		rd(OFF_OVERRIDE_VALUE, 32'h0000_0000);
		rd(OFF_RELAY_A_SOURCE, 32'h0000_0000);
		$display("test mid-run reset done");
		summarize();
	end
endmodule // tb_top
`default_nettype wire
